// ### hdl/ssw_bus_if.sv
// register access strobes between the bus slave and the status core
`timescale 1ns/1ns
interface ssw_bus_if;
    logic       wr;
    logic       rd;
    logic [7:0] adr;
    logic [7:0] wdat;
    logic [7:0] wsel;
    logic [31:0] rdat;
    modport slave  (output wr, output rd, output adr, output wdat, output wsel, input rdat);
    modport core   (input wr, input rd, input adr, input wdat, input wsel, output rdat);
endinterface

// ### hdl/ssw_defs.svh
// constants of the servo status word block
// How it works
// - clear command restores parameter registers to defaults
// - pass counter counts end-of-test markers, readable
// - code word is fault byte plus status byte
// - fault bits 0-6: adapters, rom, ram, timer, cpu
// - fault bit 7 summarises fault bits 0-6
// - status bit 0: last seek was normal
// - status bit 2: last seek was return-to-zero
// - status bit 1: hardware self tests complete
// - status bit 3: word sent to diagnostic processor
// - status bit 4 mirrors fault summary
// - status bit 5: last seek direction, 1=forward
// - bit 7 on cylinder above 842; no move
// - bit 7 on three crossings during settle
// - bit 7 if no lock within 500 ms
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH
// ==========================================
// register offsets (byte addresses)
`define SSW_ADR_CODE_WORD   8'h00
`define SSW_ADR_PASS_COUNT  8'h04
`define SSW_ADR_PARAM_BASE  8'h10
`define SSW_ADR_COMMAND     8'h08
`define SSW_ADR_IRQ_STATUS  8'h0C
`define SSW_ADR_IRQ_MASK    8'h30
`define SSW_ADR_FAULT_SET   8'h34
`define SSW_ADR_STATUS_CTRL 8'h38
// ==========================================
// commands
`define SSW_CMD_CLEAR_PARAM 8'h99
`define SSW_CMD_SEND_WORD   8'h9B
// ==========================================
// field positions
`define SSW_FLT_SUMMARY     7
`define SSW_ST_NORMAL       0
`define SSW_ST_SELFTEST     1
`define SSW_ST_RET_ZERO     2
`define SSW_ST_SENT         3
`define SSW_ST_HWERR        4
`define SSW_ST_DIR          5
`define SSW_ST_UNUSED       6
`define SSW_ST_SEEKERR      7
// ==========================================
// limits and timing
`define SSW_MAX_CYL         10'd842
`define SSW_SETTLE_XINGS    2'd3
`define SSW_PARAM_DEFAULT   8'h00
`define SSW_LOCK_TIMEOUT_MS 500
`define SSW_CLK_KHZ         125000
`define SSW_LOCK_CYCLES     (`SSW_LOCK_TIMEOUT_MS * `SSW_CLK_KHZ)
// ==========================================
// interrupt bits
`define SSW_IRQ_FAULT       0
`define SSW_IRQ_SEEKERR     1
`define SSW_IRQ_PASS        2
`define SSW_IRQ_SELFTEST    3
`endif

// ### hdl/ssw_pkg.sv
// types of the servo status word block
package ssw_pkg;
    typedef enum logic [1:0] {
        SSW_IDLE,
        SSW_SEEK,
        SSW_SETTLE
    } ssw_seek_e;
    typedef logic [7:0] ssw_byte_t;
endpackage

// ### hdl/ssw_top.sv
// servo status word: fault byte, status byte, pass counter, parameters
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`include "ssw_defs.svh"
module ssw_top
#(
    parameter int unsigned LOCK_CYCLES = `SSW_LOCK_CYCLES,
    parameter int unsigned NUM_PARAMS  = 8
)
(
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [3:0]   wb_sel_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic [6:0]   fault_event,
    input  wire logic         selftest_done,
    input  wire logic         end_of_test_marker,
    input  wire logic         seek_start,
    input  wire logic         return_to_zero_seek,
    input  wire logic         seek_forward,
    input  wire logic [9:0]   seek_cylinder,
    input  wire logic         track_crossing,
    input  wire logic         settle_start,
    input  wire logic         cylinder_lock,
    output logic              carriage_move_ff,
    output ssw_pkg::ssw_byte_t code_fault_ff,
    output ssw_pkg::ssw_byte_t code_status_ff,
    output logic              irq_ff
);
    import ssw_pkg::*;

    ssw_bus_if bus();

    ssw_wb_slave u_slave
    (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_dat_i (wb_dat_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .bus      (bus)
    );

    // ==========================================
    // decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_adr);
        hit = (a == ref_adr);
    endfunction

    logic cmd_wr;
    logic clear_param;
    logic send_word;
    assign cmd_wr      = bus.wr && hit(bus.adr, `SSW_ADR_COMMAND) && bus.wsel[0];
    assign clear_param = cmd_wr && (bus.wdat == `SSW_CMD_CLEAR_PARAM);
    assign send_word   = cmd_wr && (bus.wdat == `SSW_CMD_SEND_WORD);

    // ==========================================
    // parameter group
    ssw_byte_t param_ff [NUM_PARAMS];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PARAMS; gi++)
        begin : g_param
            always_ff @(posedge clk_sys)
            begin
                if (!resetn || clear_param)
                    param_ff[gi] <= `SSW_PARAM_DEFAULT;
                else if (bus.wr && bus.wsel[0]
                         && hit(bus.adr, `SSW_ADR_PARAM_BASE + 8'(gi * 4)))
                    param_ff[gi] <= bus.wdat;
            end
        end
    endgenerate

    // ==========================================
    // pass counter
    logic [15:0] pass_count_ff;
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pass_count_ff <= 16'h0000;
        else if (end_of_test_marker)
            pass_count_ff <= pass_count_ff + 16'h0001;
    end

    // ==========================================
    // fault byte, sticky until reset
    logic [6:0] fault_ff;
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            fault_ff <= 7'h00;
        else
            fault_ff <= fault_ff | fault_event;
    end

    // ==========================================
    // seek supervision
    ssw_seek_e   seek_ff;
    logic [31:0] lock_cnt_ff;
    logic [1:0]  xing_cnt_ff;
    logic        seek_err_ff;
    logic        ret_zero_ff;
    logic        normal_ff;
    logic        dir_ff;
    logic        bad_cyl;
    // a cylinder above the limit is refused before the carriage moves
    assign bad_cyl = seek_start && !return_to_zero_seek && (seek_cylinder > `SSW_MAX_CYL);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ret_zero_ff <= 1'b0;
            normal_ff   <= 1'b0;
            dir_ff      <= 1'b0;
        end
        else if (seek_start)
        begin
            ret_zero_ff <= return_to_zero_seek;
            normal_ff   <= !return_to_zero_seek;
            dir_ff      <= seek_forward;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            seek_ff          <= SSW_IDLE;
            lock_cnt_ff      <= 32'd0;
            xing_cnt_ff      <= 2'd0;
            carriage_move_ff <= 1'b0;
        end
        else
        begin
            case (seek_ff)
                SSW_IDLE:
                begin
                    lock_cnt_ff <= 32'd0;
                    xing_cnt_ff <= 2'd0;
                    if (seek_start && !bad_cyl)
                    begin
                        seek_ff          <= SSW_SEEK;
                        carriage_move_ff <= 1'b1;
                    end
                    else
                        carriage_move_ff <= 1'b0;
                end
                SSW_SEEK, SSW_SETTLE:
                begin
                    lock_cnt_ff <= lock_cnt_ff + 32'd1;
                    if (seek_ff == SSW_SEEK && settle_start)
                        seek_ff <= SSW_SETTLE;
                    if (seek_ff == SSW_SETTLE && track_crossing
                        && xing_cnt_ff != `SSW_SETTLE_XINGS)
                        xing_cnt_ff <= xing_cnt_ff + 2'd1;
                    if (cylinder_lock || lock_cnt_ff >= LOCK_CYCLES - 1)
                    begin
                        seek_ff          <= SSW_IDLE;
                        carriage_move_ff <= 1'b0;
                    end
                end
                default:
                    seek_ff <= SSW_IDLE;
            endcase
        end
    end

    logic xing_err;
    logic lock_err;
    assign xing_err = (seek_ff == SSW_SETTLE) && track_crossing
                      && (xing_cnt_ff == 2'd2);
    assign lock_err = (seek_ff != SSW_IDLE) && !cylinder_lock
                      && (lock_cnt_ff >= LOCK_CYCLES - 1);

    // error holds until the next seek starts; a new error wins
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            seek_err_ff <= 1'b0;
        else if (bad_cyl || xing_err || lock_err)
            seek_err_ff <= 1'b1;
        else if (seek_start)
            seek_err_ff <= 1'b0;
    end

    // ==========================================
    // self test and transmission flags
    logic selftest_ff;
    logic sent_ff;
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            selftest_ff <= 1'b0;
            sent_ff     <= 1'b0;
        end
        else
        begin
            if (selftest_done)
                selftest_ff <= 1'b1;
            if (send_word)
                sent_ff <= 1'b1;
        end
    end

    // ==========================================
    // code word
    ssw_byte_t nxt_fault;
    ssw_byte_t nxt_status;
    always_comb
    begin
        nxt_fault                      = {1'b0, fault_ff};
        nxt_fault[`SSW_FLT_SUMMARY]    = |fault_ff;
        nxt_status                     = 8'h00;
        nxt_status[`SSW_ST_NORMAL]     = normal_ff;
        nxt_status[`SSW_ST_SELFTEST]   = selftest_ff;
        nxt_status[`SSW_ST_RET_ZERO]   = ret_zero_ff;
        nxt_status[`SSW_ST_SENT]       = sent_ff;
        nxt_status[`SSW_ST_HWERR]      = |fault_ff;
        nxt_status[`SSW_ST_DIR]        = dir_ff;
        nxt_status[`SSW_ST_UNUSED]     = 1'b0;
        nxt_status[`SSW_ST_SEEKERR]    = seek_err_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            code_fault_ff  <= 8'h00;
            code_status_ff <= 8'h00;
        end
        else
        begin
            code_fault_ff  <= nxt_fault;
            code_status_ff <= nxt_status;
        end
    end

    // ==========================================
    // interrupts: sticky status, write one to clear, set wins
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic [3:0] irq_evt;
    logic [3:0] irq_clr;
    assign irq_evt = {selftest_done, end_of_test_marker,
                      bad_cyl | xing_err | lock_err, |fault_event};
    assign irq_clr = (bus.wr && bus.wsel[0] && hit(bus.adr, `SSW_ADR_IRQ_STATUS))
                     ? bus.wdat[3:0] : 4'h0;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            irq_stat_ff <= 4'h0;
            irq_mask_ff <= 4'h0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
            if (bus.wr && bus.wsel[0] && hit(bus.adr, `SSW_ADR_IRQ_MASK))
                irq_mask_ff <= bus.wdat[3:0];
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ==========================================
    // read mux
    always_comb
    begin
        bus.rdat = 32'h0000_0000;
        // held at zero outside a read, so the mux stays quiet between cycles
        if (!bus.rd)
            bus.rdat = 32'h0000_0000;
        else if (hit(bus.adr, `SSW_ADR_CODE_WORD))
            bus.rdat = {16'h0000, code_fault_ff, code_status_ff};
        else if (hit(bus.adr, `SSW_ADR_PASS_COUNT))
            bus.rdat = {16'h0000, pass_count_ff};
        else if (hit(bus.adr, `SSW_ADR_IRQ_STATUS))
            bus.rdat = {28'h0000000, irq_stat_ff};
        else if (hit(bus.adr, `SSW_ADR_IRQ_MASK))
            bus.rdat = {28'h0000000, irq_mask_ff};
        else
        begin
            for (int i = 0; i < NUM_PARAMS; i++)
                if (hit(bus.adr, `SSW_ADR_PARAM_BASE + 8'(i * 4)))
                    bus.rdat = {24'h000000, param_ff[i]};
        end
    end
endmodule

// ### hdl/ssw_wb_slave.sv
// classic wishbone slave turning bus cycles into one-cycle strobes
`timescale 1ns/1ns
module ssw_wb_slave
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    ssw_bus_if.slave         bus
);
    // ==========================================
    // strobes, ack one cycle after the request
    logic req;
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus.wr   = req && wb_we_i;
    assign bus.rd   = req && !wb_we_i;
    assign bus.adr  = {wb_adr_i[7:2], 2'b00};
    assign bus.wdat = wb_dat_i[7:0];
    // only the low byte lane carries data
    assign bus.wsel = {8{wb_sel_i[0]}};

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
                wb_dat_o <= bus.rdat;
        end
    end
endmodule

// ### tb/servo_status_word_tb.sv
// self-checking bench for the servo status word block
`timescale 1ns/1ns
`include "ssw_defs.svh"
module servo_status_word_tb;
    import ssw_pkg::*;
    localparam int unsigned LOCK_CYC = 50;
    logic        clk_sys;
    logic        resetn;
    logic        cyc, stb, we, ack, irq_ff, carriage_move_ff;
    logic [7:0]  adr;
    logic [31:0] dat_w, dat_r, q;
    logic [3:0]  sel;
    logic [6:0]  fault_event;
    logic        seek_start, return_to_zero_seek, seek_forward;
    logic [9:0]  seek_cylinder;
    logic [4:0]  ev;
    ssw_byte_t   code_fault_ff, code_status_ff;
    logic [7:0]  fl, st;
    logic [7:0]  pv [8];
    int          n_fail, tests_run, i, n;
    ssw_top #(.LOCK_CYCLES(LOCK_CYC)) uut (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .fault_event(fault_event),
        .selftest_done(ev[4]), .end_of_test_marker(ev[3]), .seek_start(seek_start),
        .return_to_zero_seek(return_to_zero_seek), .seek_forward(seek_forward),
        .seek_cylinder(seek_cylinder), .track_crossing(ev[2]), .settle_start(ev[1]),
        .cylinder_lock(ev[0]), .carriage_move_ff(carriage_move_ff),
        .code_fault_ff(code_fault_ff), .code_status_ff(code_status_ff), .irq_ff(irq_ff));
    ssw_diag_model m (.clk_sys(clk_sys), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .dat_w(dat_w), .sel(sel));
    // ==========================================
    // helpers
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // fault byte expected from the event bits: summary on top of bits 6:0
    function automatic logic [7:0] exp_fault(input logic [6:0] f);
        exp_fault = {|f, f};
    endfunction
    task tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // event mask: 10 self test, 08 marker, 04 crossing, 02 settle, 01 lock
    task pulse(input logic [4:0] e);
        @(posedge clk_sys);
        ev <= e;
        @(posedge clk_sys);
        ev <= 5'h00;
    endtask
    task do_reset;
        @(posedge clk_sys);
        resetn <= 1'b0;
        tick(3);
        resetn <= 1'b1;
        fl = 8'h00;
        st = 8'h00;
    endtask
    task chk_word;
        tick(2);
        m.xfer(1'b0, `SSW_ADR_CODE_WORD, 32'h0, q);
        chk("code word", q, {16'h0, fl, st});
        chk("status port", code_status_ff, st);
        chk("fault port", code_fault_ff, fl);
    endtask
    task seek(input logic r, input logic f, input logic [9:0] c);
        @(posedge clk_sys);
        seek_start <= 1'b1;
        return_to_zero_seek <= r;
        seek_forward <= f;
        seek_cylinder <= c;
        @(posedge clk_sys);
        seek_start <= 1'b0;
        st[0] = !r;
        st[2] = r;
        st[5] = f;
        st[7] = !r && (c > 10'd842);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // clock, watchdog, tests
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        tick(20000);
        n_fail++;
        finish_test();
    end
    initial
    begin
        resetn = 1'b0;
        ev = 5'h00;
        fault_event = 7'h00;
        seek_start = 1'b0;
        return_to_zero_seek = 1'b0;
        seek_forward = 1'b0;
        seek_cylinder = 10'h000;
        n_fail = 0;
        tests_run = 0;
        q = $urandom(96);
        for (i = 0; i < 7; i++)
        begin
            do_reset();
            @(posedge clk_sys);
            fault_event <= 7'h01 << i;
            @(posedge clk_sys);
            fault_event <= 7'h00;
            fl = exp_fault(7'h01 << i);
            st = 8'h10;
            chk_word();
        end
        $display("fault byte test done");
        do_reset();
        m.xfer(1'b1, 8'h3C, $urandom, q);
        m.xfer(1'b0, 8'h3C, 32'h0, q);
        chk("unmapped", q, 32'h0);
        m.xfer(1'b1, `SSW_ADR_IRQ_MASK, 32'h4, q);
        pulse(5'h08);
        tick(2);
        chk("irq raised", irq_ff, 1'b1);
        m.xfer(1'b1, `SSW_ADR_IRQ_STATUS, 32'h4, q);
        tick(2);
        chk("irq cleared", irq_ff, 1'b0);
        m.xfer(1'b1, `SSW_ADR_IRQ_MASK, 32'h0, q);
        pulse(5'h08);
        tick(2);
        chk("irq masked", irq_ff, 1'b0);
        m.xfer(1'b0, `SSW_ADR_IRQ_STATUS, 32'h0, q);
        chk("irq status", q, 32'h4);
        n = $urandom_range(3, 20);
        repeat (n) pulse(5'h08);
        tick(2);
        m.xfer(1'b0, `SSW_ADR_PASS_COUNT, 32'h0, q);
        chk("pass counter", q, n + 2);
        $display("irq and pass counter test done");
        for (i = 0; i < 8; i++)
        begin
            pv[i] = 8'($urandom_range(1, 255));
            m.xfer(1'b1, `SSW_ADR_PARAM_BASE + 8'(4 * i), {24'h0, pv[i]}, q);
        end
        m.xfer(1'b0, `SSW_ADR_PARAM_BASE + 8'h1C, 32'h0, q);
        chk("param write", q, {24'h0, pv[7]});
        m.xfer(1'b1, `SSW_ADR_COMMAND, {24'h0, `SSW_CMD_CLEAR_PARAM}, q);
        for (i = 0; i < 8; i++)
        begin
            m.xfer(1'b0, `SSW_ADR_PARAM_BASE + 8'(4 * i), 32'h0, q);
            chk("param default", q, 32'h0);
        end
        pulse(5'h10);
        m.xfer(1'b1, `SSW_ADR_COMMAND, {24'h0, `SSW_CMD_SEND_WORD}, q);
        st[1] = 1'b1;
        st[3] = 1'b1;
        chk_word();
        $display("parameter and command test done");
        for (i = 0; i < 6; i++)
        begin
            seek($urandom, $urandom, (i == 0) ? 10'd842 : 10'($urandom_range(0, 842)));
            tick(2);
            chk("carriage", carriage_move_ff, 1'b1);
            chk_word();
            pulse(5'h01);
            tick(2);
            chk("carriage idle", carriage_move_ff, 1'b0);
        end
        seek(1'b0, 1'b1, 10'd843);
        chk_word();
        chk("no move", carriage_move_ff, 1'b0);
        for (i = 2; i < 4; i++)
        begin
            seek(1'b0, 1'b0, 10'd100);
            pulse(5'h02);
            repeat (i) pulse(5'h04);
            pulse(5'h01);
            st[7] = (i == 3);
            chk_word();
        end
        seek(1'b1, 1'b0, 10'd0);
        tick(LOCK_CYC + 5);
        st[7] = 1'b1;
        chk_word();
        chk("timeout stop", carriage_move_ff, 1'b0);
        // seek errors, markers and self test have all raised their sticky bits
        m.xfer(1'b0, `SSW_ADR_IRQ_STATUS, 32'h0, q);
        chk("irq sources", q, 32'h0000000E);
        $display("seek test done");
        finish_test();
    end
endmodule

// ### tb/ssw_diag_model.sv
// diagnostic processor model: classic wishbone master reading the status word
`timescale 1ns/1ns
module ssw_diag_model
(
    input  wire logic        clk_sys,
    input  wire logic        ack,
    input  wire logic [31:0] dat_r,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [31:0]      dat_w,
    output logic [3:0]       sel
);
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat_w = 32'h0;
        sel = 4'h0;
    end
    // request held until ack is seen at an edge; released address and data lines show the inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~a;
        dat_w <= ~d;
    endtask
endmodule

// ### tb/ssw_top_monitor.sv
// assertion checker on the ports of the servo status word top
`timescale 1ns/1ns
`include "ssw_defs.svh"
module ssw_top_monitor
#(
    parameter int unsigned LOCK_CYCLES = 50
)
(
    input wire logic               clk_sys,
    input wire logic               resetn,
    input wire logic [6:0]         fault_event,
    input wire logic               selftest_done,
    input wire logic               seek_start,
    input wire logic               return_to_zero_seek,
    input wire logic               seek_forward,
    input wire logic [9:0]         seek_cylinder,
    input wire logic               carriage_move_ff,
    input wire ssw_pkg::ssw_byte_t code_fault_ff,
    input wire ssw_pkg::ssw_byte_t code_status_ff
);
    import ssw_pkg::*;
    // ==========================================
    // properties; one clock, one reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_fault_summary: assert property (code_fault_ff[7] == (|code_fault_ff[6:0]))
        else $error("fault summary bit wrong");
    a_hwerr_mirror: assert property (code_status_ff[4] == (|code_fault_ff[6:0]))
        else $error("status hardware error bit wrong");
    a_unused_zero: assert property (code_status_ff[6] == 1'b0)
        else $error("unused status bit set");
    a_fault_sticks: assert property (fault_event[0] |-> ##[1:2] code_fault_ff[0])
        else $error("adapter fault not flagged");
    a_selftest_flag: assert property (selftest_done |-> ##[1:2] code_status_ff[1])
        else $error("self test flag not set");
    a_normal_seek: assert property (seek_start && !return_to_zero_seek
        |-> ##[1:2] (code_status_ff[0] && !code_status_ff[2])) else $error("normal seek bits");
    a_return_seek: assert property (seek_start && return_to_zero_seek
        |-> ##[1:2] (code_status_ff[2] && !code_status_ff[0]))
        else $error("return-to-zero seek bits");
    a_seek_dir: assert property (seek_start && seek_forward |-> ##[1:2] code_status_ff[5])
        else $error("forward direction not shown");
    a_far_cyl: assert property (seek_start && !return_to_zero_seek
        && seek_cylinder > `SSW_MAX_CYL |-> ##[1:2] code_status_ff[7]) else $error("far seek");
    a_no_move: assert property (seek_start && !return_to_zero_seek
        && seek_cylinder > `SSW_MAX_CYL |=> !carriage_move_ff [*3]) else $error("carriage moved");
endmodule
bind ssw_top ssw_top_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (.clk_sys(clk_sys),
    .resetn(resetn), .fault_event(fault_event), .selftest_done(selftest_done),
    .seek_start(seek_start), .return_to_zero_seek(return_to_zero_seek),
    .seek_forward(seek_forward), .seek_cylinder(seek_cylinder),
    .carriage_move_ff(carriage_move_ff), .code_fault_ff(code_fault_ff),
    .code_status_ff(code_status_ff));
